// [core/rsi_regs.sv]
// Purpose: read-only status and identification registers of the repeater
// Assumes: local and remote read ports, one-cycle read latency
// Notes:   writes are accepted and discarded
`timescale 1ns/1ps
`default_nettype none
module rsi_regs
  import rsi_pkg::*;
#(
  parameter logic [3:0] BaseStep  = 4'h1, // arbitrary value
  parameter logic [3:0] MetalStep = 4'h0, // arbitrary value
  parameter logic [7:0] PartLow   = 8'h5a, // arbitrary value
  parameter logic [7:0] PartHigh  = 8'ha5, // arbitrary value
  parameter logic [3:0] CfgImage  = 4'h3, // arbitrary value
  parameter logic [1:0] ChipType  = 2'h2  // arbitrary value
)(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       locRead,
  input  wire logic       locWrite,
  input  wire logic [7:0] locAddr,
  input  wire logic [7:0] locWdata,
  input  wire logic       remRead,
  input  wire logic [7:0] remAddr,
  input  wire logic [7:0] remoteKey,
  input  wire logic       liveValid,
  input  wire logic [1:0] liveSpeed,
  input  wire logic [1:0] liveRole,
  input  wire logic [2:0] liveLink,
  output logic      [7:0] locRdata,
  output logic            locRvalid,
  output logic      [7:0] remRdata,
  output logic            remRvalid,
  output logic            remDenied,
  output logic      [7:0] devStatusOut,
  output logic      [7:0] linkStatusOut
);
  import rsi_pkg::*;

  logic [7:0] devNow;
  logic [7:0] linkNow;
  logic [7:0] devStatus_q,  devStatus_d;
  logic [7:0] linkStatus_q, linkStatus_d;
  logic [7:0] locRdata_q,   locRdata_d;
  logic       locRvalid_q,  locRvalid_d;
  logic [7:0] remRdata_q,   remRdata_d;
  logic       remRvalid_q,  remRvalid_d;
  logic       remDenied_q,  remDenied_d;
  logic       remOk;

  rsi_status_fields uFields (
    .liveValid  (liveValid),
    .liveSpeed  (liveSpeed),
    .liveRole   (liveRole),
    .liveLink   (liveLink),
    .devStatus  (devNow),
    .linkStatus (linkNow)
  );

  function automatic logic [7:0] readMux(input logic [7:0] addr, input logic [7:0] dev,
                                         input logic [7:0] lnk);
    case (addr)
      OffDevStatus:  readMux = dev;
      OffLinkStatus: readMux = lnk;
      OffSiliconRev: readMux = {BaseStep, MetalStep};
      OffPartLow:    readMux = PartLow;
      OffPartHigh:   readMux = PartHigh;
      OffCfgType:    readMux = {CfgImage, 2'b00, ChipType};
      default:       readMux = ReadZero;
    endcase
  endfunction : readMux

  function automatic logic remoteMapped(input logic [7:0] addr);
    remoteMapped = (addr == OffDevStatus) || (addr == OffLinkStatus) ||
                   (addr == OffSiliconRev) || (addr == OffPartLow) ||
                   (addr == OffPartHigh) || (addr == OffCfgType);
  endfunction : remoteMapped

  assign remOk = (remoteKey == RemoteKeyOpen) && remoteMapped(remAddr);

  always_comb
  begin
    devStatus_d  = devNow;
    linkStatus_d = linkNow;
    locRvalid_d  = locRead;
    locRdata_d   = locRead ? readMux(locAddr, devNow, linkNow) : ReadZero;
    remRvalid_d  = remRead;
    remRdata_d   = (remRead && remOk) ? readMux(remAddr, devNow, linkNow) : ReadZero;
    remDenied_d  = remRead && !remOk;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      devStatus_q  <= ReadZero;
      linkStatus_q <= ReadZero;
      locRdata_q   <= ReadZero;
      locRvalid_q  <= 1'b0;
      remRdata_q   <= ReadZero;
      remRvalid_q  <= 1'b0;
      remDenied_q  <= 1'b0;
    end
    else
    begin
      devStatus_q  <= devStatus_d;
      linkStatus_q <= linkStatus_d;
      locRdata_q   <= locRdata_d;
      locRvalid_q  <= locRvalid_d;
      remRdata_q   <= remRdata_d;
      remRvalid_q  <= remRvalid_d;
      remDenied_q  <= remDenied_d;
    end
  end

  assign devStatusOut  = devStatus_q;
  assign linkStatusOut = linkStatus_q;
  assign locRdata      = locRdata_q;
  assign locRvalid     = locRvalid_q;
  assign remRdata      = remRdata_q;
  assign remRvalid     = remRvalid_q;
  assign remDenied     = remDenied_q;

  // locWrite/locWdata are deliberately unused: every register here is read-only
  logic unusedWrite;
  assign unusedWrite = locWrite ^ (^locWdata);

  property p_status_ro;
    @(posedge clk_sys) disable iff (rst)
      locWrite && !$past(rst) && $stable(liveSpeed) && $stable(liveRole) |=>
        devStatus_q == $past(devStatus_q);
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("status changed on write");

  property p_speed;
    @(posedge clk_sys) disable iff (rst) 1 |=> devStatus_q[3:2] == $past(liveSpeed);
  endproperty
  a_speed: assert property (p_speed) else $error("speed field wrong");

  property p_role;
    @(posedge clk_sys) disable iff (rst) 1 |=> devStatus_q[1:0] == $past(liveRole);
  endproperty
  a_role: assert property (p_role) else $error("role field wrong");

  property p_link;
    @(posedge clk_sys) disable iff (rst) liveValid |=> linkStatus_q[2:0] == $past(liveLink);
  endproperty
  a_link: assert property (p_link) else $error("link field wrong");

  property p_trans;
    @(posedge clk_sys) disable iff (rst) !liveValid |=> linkStatus_q[2:0] == 3'b111;
  endproperty
  a_trans: assert property (p_trans) else $error("transition code missing");

  property p_rev;
    @(posedge clk_sys) disable iff (rst)
      locRead && locAddr == OffSiliconRev |=> locRvalid && locRdata == {BaseStep, MetalStep};
  endproperty
  a_rev: assert property (p_rev) else $error("revision read wrong");

  property p_part;
    @(posedge clk_sys) disable iff (rst)
      locRead && locAddr == OffPartHigh |=> locRdata == PartHigh;
  endproperty
  a_part: assert property (p_part) else $error("part high read wrong");

  property p_remote_block;
    @(posedge clk_sys) disable iff (rst)
      remRead && remoteKey != RemoteKeyOpen |=> remDenied && remRdata == ReadZero;
  endproperty
  a_remote_block: assert property (p_remote_block) else $error("remote read not blocked");

  property p_reserved;
    @(posedge clk_sys) disable iff (rst)
      1 |=> devStatus_q[7:4] == 4'h0 && linkStatus_q[7:3] == 5'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits set");

  property p_link_ro;
    @(posedge clk_sys) disable iff (rst)
      locWrite && !$past(rst) && liveValid && $past(liveValid) && $stable(liveLink) |=>
        linkStatus_q == $past(linkStatus_q);
  endproperty
  a_link_ro: assert property (p_link_ro) else $error("link status changed on write");

  property p_dev_read;
    @(posedge clk_sys) disable iff (rst)
      locRead && locAddr == OffDevStatus |=> locRdata == {4'h0, $past(liveSpeed), $past(liveRole)};
  endproperty
  a_dev_read: assert property (p_dev_read) else $error("status read wrong");

  property p_link_read;
    @(posedge clk_sys) disable iff (rst)
      locRead && locAddr == OffLinkStatus && liveValid |=> locRdata == {5'h00, $past(liveLink)};
  endproperty
  a_link_read: assert property (p_link_read) else $error("link read wrong");

  property p_metal;
    @(posedge clk_sys) disable iff (rst)
      locRead && locAddr == OffSiliconRev |=> locRdata[3:0] == MetalStep;
  endproperty
  a_metal: assert property (p_metal) else $error("metal step wrong");

  property p_part_low;
    @(posedge clk_sys) disable iff (rst)
      locRead && locAddr == OffPartLow |=> locRdata == PartLow;
  endproperty
  a_part_low: assert property (p_part_low) else $error("part low read wrong");

  property p_cfg;
    @(posedge clk_sys) disable iff (rst)
      locRead && locAddr == OffCfgType |=> locRdata[7:4] == CfgImage && locRdata[1:0] == ChipType;
  endproperty
  a_cfg: assert property (p_cfg) else $error("config and type read wrong");

  property p_cfg_reserved_field;
    @(posedge clk_sys) disable iff (rst)
      locRead && locAddr == OffCfgType |=> locRdata[3:2] == 2'b00;
  endproperty
  a_cfg_reserved_field: assert property (p_cfg_reserved_field) else $error("config reserved bits set");

  property p_loc_unmapped;
    @(posedge clk_sys) disable iff (rst)
      locRead && !remoteMapped(locAddr) |=> locRdata == ReadZero;
  endproperty
  a_loc_unmapped: assert property (p_loc_unmapped) else $error("unmapped local read not zero");

  property p_loc_valid;
    @(posedge clk_sys) disable iff (rst)
      locRead |=> locRvalid;
  endproperty
  a_loc_valid: assert property (p_loc_valid) else $error("local read not answered");

  property p_loc_idle;
    @(posedge clk_sys) disable iff (rst)
      !locRead |=> !locRvalid && locRdata == ReadZero;
  endproperty
  a_loc_idle: assert property (p_loc_idle) else $error("local answer without read");

  property p_rem_valid;
    @(posedge clk_sys) disable iff (rst)
      remRead |=> remRvalid;
  endproperty
  a_rem_valid: assert property (p_rem_valid) else $error("remote read not answered");

  property p_rem_idle;
    @(posedge clk_sys) disable iff (rst)
      !remRead |=> !remRvalid && !remDenied && remRdata == ReadZero;
  endproperty
  a_rem_idle: assert property (p_rem_idle) else $error("remote answer without read");

  property p_rem_key_zero;
    @(posedge clk_sys) disable iff (rst)
      remRead && remoteKey == RemoteKeyNone |=> remDenied && remRdata == ReadZero;
  endproperty
  a_rem_key_zero: assert property (p_rem_key_zero) else $error("closed key let a read through");

  property p_rem_unmapped;
    @(posedge clk_sys) disable iff (rst)
      remRead && !remoteMapped(remAddr) |=> remDenied && remRdata == ReadZero;
  endproperty
  a_rem_unmapped: assert property (p_rem_unmapped) else $error("unmapped remote read not refused");

  property p_rem_dev;
    @(posedge clk_sys) disable iff (rst)
      remRead && remoteKey == RemoteKeyOpen && remAddr == OffDevStatus |=>
        !remDenied && remRdata == {4'h0, $past(liveSpeed), $past(liveRole)};
  endproperty
  a_rem_dev: assert property (p_rem_dev) else $error("remote status read wrong");

  property p_rem_link;
    @(posedge clk_sys) disable iff (rst)
      remRead && remoteKey == RemoteKeyOpen && remAddr == OffLinkStatus && !liveValid |=>
        !remDenied && remRdata == {5'h00, LnkTransition};
  endproperty
  a_rem_link: assert property (p_rem_link) else $error("remote transition code wrong");

  property p_rem_rev;
    @(posedge clk_sys) disable iff (rst)
      remRead && remoteKey == RemoteKeyOpen && remAddr == OffSiliconRev |=>
        !remDenied && remRdata == {BaseStep, MetalStep};
  endproperty
  a_rem_rev: assert property (p_rem_rev) else $error("remote revision read wrong");

  property p_rem_part;
    @(posedge clk_sys) disable iff (rst)
      remRead && remoteKey == RemoteKeyOpen && remAddr == OffPartLow |=> !remDenied && remRdata == PartLow;
  endproperty
  a_rem_part: assert property (p_rem_part) else $error("remote part low read wrong");

  c_remote_ok: cover property (@(posedge clk_sys) disable iff (rst) remRead && remOk ##1 remRvalid);
  c_trans: cover property (@(posedge clk_sys) disable iff (rst) !liveValid ##1 liveValid);
  c_write: cover property (@(posedge clk_sys) disable iff (rst) locWrite && locAddr == OffDevStatus);
  c_deny: cover property (@(posedge clk_sys) disable iff (rst) remRead && remoteKey == RemoteKeyNone ##1 remDenied);
  c_rev: cover property (@(posedge clk_sys) disable iff (rst) locRead && locAddr == OffSiliconRev ##1 locRvalid);
endmodule : rsi_regs
`default_nettype wire

// [core/rsi_pkg.sv]
// Purpose: constants for the repeater status and identification register group
// Assumes: byte-wide registers at their printed offsets
// Notes:   identification values are parameters of the top module
package rsi_pkg;
  localparam logic [7:0] OffDevStatus  = 8'h0f;
  localparam logic [7:0] OffLinkStatus = 8'h10;
  localparam logic [7:0] OffSiliconRev = 8'h13;
  localparam logic [7:0] OffPartLow    = 8'h14;
  localparam logic [7:0] OffPartHigh   = 8'h15;
  localparam logic [7:0] OffCfgType    = 8'h16;
  localparam logic [7:0] RemoteKeyOpen = 8'h37;
  localparam logic [7:0] RemoteKeyNone = 8'h00;
  localparam logic [7:0] ReadZero      = 8'h00;
  localparam int         SpeedLsb      = 2;
  localparam int         RoleLsb       = 0;
  localparam int         BaseStepLsb   = 4;
  localparam int         CfgImageLsb   = 4;
  typedef enum logic [1:0] {
    SpdLow  = 2'b00,
    SpdFull = 2'b01,
    SpdHigh = 2'b10
  } rsi_speed_t;
  typedef enum logic [1:0] {
    RoleNone   = 2'b00,
    RoleDevice = 2'b01,
    RoleHost   = 2'b10
  } rsi_role_t;
  typedef enum logic [2:0] {
    LnkDeepStandby = 3'b000,
    LnkConnDetect  = 3'b001,
    LnkL1          = 3'b010,
    LnkL2          = 3'b011,
    LnkActiveHs    = 3'b101,
    LnkCompliance  = 3'b110,
    LnkTransition  = 3'b111
  } rsi_link_t;
endpackage : rsi_pkg

// [core/rsi_status_fields.sv]
// Purpose: packs live repeater state into the two status bytes
// Assumes: inputs synchronous to clk_sys
// Notes:   combinational; the top registers the result
`timescale 1ns/1ps
`default_nettype none
module rsi_status_fields
  import rsi_pkg::*;
(
  input  wire logic       liveValid,
  input  wire logic [1:0] liveSpeed,
  input  wire logic [1:0] liveRole,
  input  wire logic [2:0] liveLink,
  output logic      [7:0] devStatus,
  output logic      [7:0] linkStatus
);
  always_comb
  begin
    devStatus  = {4'h0, liveSpeed, liveRole};
    linkStatus = {5'h00, liveValid ? liveLink : LnkTransition};
  end
endmodule : rsi_status_fields
`default_nettype wire

// [verification/rsi_remote_host.sv]
// Purpose: remote access host that issues read requests to the register group
// Assumes: requests launched just after a rising edge of clk_sys
// Notes:   address inverted between requests so a stale value never matches
`timescale 1ns/1ps
`default_nettype none
module rsi_remote_host
(
  input  wire logic       clk_sys,
  output logic            remRead,
  output logic      [7:0] remAddr,
  output logic      [7:0] remoteKey,
  input  wire logic [7:0] remRdata,
  input  wire logic       remRvalid,
  input  wire logic       remDenied
);
  initial
  begin
    remRead   = 1'b0;
    remAddr   = 8'h00;
    remoteKey = 8'h00;
  end
  task automatic doRead(input logic [7:0] a, input logic [7:0] k, output logic [7:0] d, output logic v,
                        output logic dn);
    @(posedge clk_sys);
    remRead   <= 1'b1;
    remAddr   <= a;
    remoteKey <= k;
    @(posedge clk_sys);
    remRead <= 1'b0;
    remAddr <= ~a;
    #1;
    d  = remRdata;
    v  = remRvalid;
    dn = remDenied;
  endtask : doRead
endmodule : rsi_remote_host
`default_nettype wire

// [verification/repeater_status_id_regs_tb.sv]
// Purpose: self-checking bench for the status and identification registers
// Assumes: reads answered right after the taking edge
// Notes:   live state held steady around each read
`timescale 1ns/1ps
`default_nettype none
module repeater_status_id_regs_tb;
  import rsi_pkg::*;
  logic        clk_sys, rst, locRead, locWrite, liveValid, locRvalid, remRead, remRvalid, remDenied, v, dn;
  logic [7:0]  locAddr, locWdata, remAddr, remoteKey, locRdata, remRdata, devStatusOut, linkStatusOut, d, k;
  logic [1:0]  liveSpeed, liveRole;
  logic [2:0]  liveLink;
  logic [15:0] lfsr;
  int          n_errors, samples_checked, cyc;
  logic [7:0]  addrs[9] = '{8'h0f, 8'h10, 8'h13, 8'h14, 8'h15, 8'h16, 8'h00, 8'h11, 8'hff};
  logic [2:0]  links[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h6};
  rsi_regs #(.BaseStep(4'h2), .PartLow(8'h6c), .PartHigh(8'h93), .CfgImage(4'h5),
    .ChipType(2'h3)) dut_u (.clk_sys, .rst, .locRead, .locWrite, .locAddr, .locWdata, .remRead, .remAddr,
    .remoteKey, .liveValid, .liveSpeed, .liveRole, .liveLink, .locRdata, .locRvalid, .remRdata, .remRvalid,
    .remDenied, .devStatusOut, .linkStatusOut);
  rsi_remote_host partnerU (.clk_sys, .remRead, .remAddr, .remoteKey, .remRdata, .remRvalid, .remDenied);
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  function automatic logic [15:0] nextRand(input logic [15:0] s);
    return {1'b0, s[15:1]} ^ (s[0] ? 16'hb400 : 16'h0000);
  endfunction : nextRand
  // behavioural register map
  function automatic logic [7:0] expv(input logic [7:0] ad);
    case (ad)
      8'h0f: return {4'h0, liveSpeed, liveRole};
      8'h10: return {5'h00, liveValid ? liveLink : 3'h7};
      8'h13: return 8'h20;
      8'h14: return 8'h6c;
      8'h15: return 8'h93;
      8'h16: return 8'h53;
      default: return 8'h00;
    endcase
  endfunction : expv
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic locRd(input logic [7:0] ad);
    @(posedge clk_sys);
    locRead <= 1'b1;
    locAddr <= ad;
    @(posedge clk_sys);
    locRead <= 1'b0;
    locAddr <= ~ad;
    #1;
    chk("locRvalid", 8'h01, {7'h00, locRvalid});
    chk("locRdata", expv(ad), locRdata);
  endtask : locRd
  task automatic final_report;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_errors++;
      final_report();
    end
  end
  initial
  begin
    rst = 1'b1; locRead = 1'b0; locWrite = 1'b0; locAddr = 8'h00; locWdata = 8'h00; liveValid = 1'b1;
    liveSpeed = 2'h0; liveRole = 2'h0; liveLink = 3'h0;
    n_errors = 0; samples_checked = 0; cyc = 0; lfsr = 16'd19495;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    chk("devStatusOut", 8'h00, devStatusOut);
    chk("linkStatusOut", 8'h00, linkStatusOut);
    for (int i = 0; i < 40; i++)
    begin
      lfsr = nextRand(lfsr);
      @(posedge clk_sys);
      liveSpeed <= 2'(lfsr[3:0] % 3);
      liveRole  <= 2'(lfsr[7:4] % 3);
      liveLink  <= links[lfsr[10:8] % 6];
      liveValid <= (i % 5) != 3;
      locAddr   <= addrs[i % 9];
      locWdata  <= lfsr[15:8];
      @(posedge clk_sys);
      locWrite <= 1'b1;
      @(posedge clk_sys);
      locWrite <= 1'b0;
      @(posedge clk_sys);
      #1;
      chk("devStatusOut", expv(8'h0f), devStatusOut);
      chk("linkStatusOut", expv(8'h10), linkStatusOut);
      for (int j = 0; j < 9; j++)
        locRd(addrs[j]);
      @(posedge clk_sys);
      #1;
      chk("locRvalidIdle", 8'h00, {7'h00, locRvalid});
      chk("locRdataIdle", 8'h00, locRdata);
      k = ((i / 9) % 3 == 0) ? 8'h37 : ((i / 9) % 3 == 1) ? 8'h00 : (lfsr[7:0] ^ {7'h00, lfsr[7:0] == 8'h37});
      partnerU.doRead(addrs[i % 9], k, d, v, dn);
      chk("remRvalid", 8'h01, {7'h00, v});
      chk("remDenied", {7'h00, !(k == 8'h37 && (i % 9) < 6)}, {7'h00, dn});
      chk("remRdata", (k == 8'h37) ? expv(addrs[i % 9]) : 8'h00, d);
      if (i == 20)
      begin
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        chk("devStatusOut", 8'h00, devStatusOut);
        chk("linkStatusOut", 8'h00, linkStatusOut);
      end
    end
    final_report();
  end
endmodule : repeater_status_id_regs_tb
`default_nettype wire
